// >>> pph_pkg.sv
package pph_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_DATA = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_CONTROL = 8'h08;
    // control register fields
    localparam int CTL_STROBE_N = 0;
    localparam int CTL_AUTO_LF_N = 1;
    localparam int CTL_INIT = 2;
    localparam int CTL_CHOOSE_N = 3;
    localparam int CTL_DIR_OUT = 4;
    localparam int CTL_PIN_LSB = 8;
    // status register fields
    localparam int STS_FAULT_N = 0;
    localparam int STS_ONLINE = 1;
    localparam int STS_BUSY = 2;
    localparam int STS_PAPER_OUT = 3;
    localparam int STS_ACK_N = 4;
    localparam int STS_IRQ_PEND = 5;
    localparam int STS_STRAP = 6;
    // reset values
    localparam logic [3:0] RST_CTL_LINES = 4'hB;
    localparam logic RST_DIR_OUT = 1'b1;
    localparam logic [7:0] RST_DATA = 8'h00;
    // synchroniser width and idle value (inputs have pull-ups)
    localparam int SYNC_W = 19;
    localparam logic [18:0] RST_SYNC = 19'h7FFFF;
endpackage

// >>> pph_port.sv
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/100ps
module pph_port (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // host port select pin
    input wire logic printer_port_select_n,
    // printer data lines
    input wire logic [7:0] printer_data_in,
    output logic [7:0] printer_data_out,
    output logic printer_data_oe,
    // open-drain control lines
    input wire logic strobe_in,
    output logic strobe_out,
    output logic strobe_oe,
    input wire logic auto_line_feed_n_in,
    output logic auto_line_feed_n_out,
    output logic auto_line_feed_n_oe,
    input wire logic init_in,
    output logic init_out,
    output logic init_oe,
    input wire logic printer_choose_n_in,
    output logic printer_choose_n_out,
    output logic printer_choose_n_oe,
    // printer status inputs
    input wire logic fault_n,
    input wire logic printer_online,
    input wire logic busy,
    input wire logic paper_out,
    input wire logic ack_n,
    // interrupt
    input wire logic irq_latch_strap,
    output logic printer_irq_n
);
    logic [pph_pkg::SYNC_W-1:0] sync_a;
    logic [pph_pkg::SYNC_W-1:0] sync_b;
    logic [pph_pkg::SYNC_W-1:0] raw_in;
    logic [7:0] data_s;
    logic [3:0] ctl_pin_s;
    logic fault_s;
    logic online_s;
    logic busy_s;
    logic paper_s;
    logic ack_s;
    logic strap_s;
    logic sel_s;
    logic ack_prev;
    logic ack_fall;
    logic irq_pend;
    logic [3:0] ctl_lines;
    logic access;
    logic done;
    logic hit_data;
    logic hit_status;
    logic hit_control;
    logic mapped;
    logic [31:0] next_rdata;
    logic [6:0] status_word;

    assign raw_in = {printer_port_select_n, irq_latch_strap, ack_n, paper_out, busy,
                     printer_online, fault_n, printer_choose_n_in, init_in,
                     auto_line_feed_n_in, strobe_in, printer_data_in};

    // two-stage synchroniser on every pin input; stage one feeds only stage two
    // no reset here: pins flush through while reset is held, so the first
    // access after release already sees settled levels, select pin included
    always_ff @(posedge clock)
    begin
        sync_a <= raw_in;
        sync_b <= sync_a;
    end

    assign data_s = sync_b[7:0];
    assign ctl_pin_s = sync_b[11:8];
    assign fault_s = sync_b[12];
    assign online_s = sync_b[13];
    assign busy_s = sync_b[14];
    assign paper_s = sync_b[15];
    assign ack_s = sync_b[16];
    assign strap_s = sync_b[17];
    assign sel_s = ~sync_b[18];

    // bus decode; transfers refused while the port select pin is high
    assign access = psel && penable;
    assign done = access && pready;
    assign hit_data = paddr == pph_pkg::OFS_DATA;
    assign hit_status = paddr == pph_pkg::OFS_STATUS;
    assign hit_control = paddr == pph_pkg::OFS_CONTROL;
    assign mapped = (hit_data || hit_status || hit_control) && sel_s;

    // status inputs double as general purpose inputs
    assign status_word = {strap_s, irq_pend, ack_s, paper_s, busy_s, online_s,
                          fault_s};

    // read mux; data reads the latch while driving and the pins in input mode
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (mapped && !pwrite)
        begin
            if (hit_data)
                next_rdata[7:0] = printer_data_oe ? printer_data_out : data_s;
            else if (hit_status)
                next_rdata[6:0] = status_word;
            else
            begin
                next_rdata[3:0] = ctl_lines;
                next_rdata[pph_pkg::CTL_DIR_OUT] = printer_data_oe;
                next_rdata[pph_pkg::CTL_PIN_LSB +: 4] = ctl_pin_s;
            end
        end
    end

    // one wait state: pready rises the cycle after the access phase opens
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else if (access && !pready)
        begin
            pready <= 1'b1;
            pslverr <= !mapped;
            prdata <= next_rdata;
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
    end

    // data latch and direction; the byte stays on the lines until rewritten
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            printer_data_out <= pph_pkg::RST_DATA;
            printer_data_oe <= pph_pkg::RST_DIR_OUT;
        end
        else if (done && mapped && pwrite)
        begin
            if (hit_data)
                printer_data_out <= pwdata[7:0];
            if (hit_control)
                printer_data_oe <= pwdata[pph_pkg::CTL_DIR_OUT];
        end
    end

    // control line levels written by software; strobe timing is software's
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            ctl_lines <= pph_pkg::RST_CTL_LINES;
        else if (done && mapped && pwrite && hit_control)
            ctl_lines <= pwdata[3:0];
    end

    // open drain: pull low when the bit is zero, release otherwise
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            strobe_out <= 1'b0;
            auto_line_feed_n_out <= 1'b0;
            init_out <= 1'b0;
            printer_choose_n_out <= 1'b0;
            strobe_oe <= !pph_pkg::RST_CTL_LINES[pph_pkg::CTL_STROBE_N];
            auto_line_feed_n_oe <= !pph_pkg::RST_CTL_LINES[pph_pkg::CTL_AUTO_LF_N];
            init_oe <= !pph_pkg::RST_CTL_LINES[pph_pkg::CTL_INIT]; // init pin low in reset
            printer_choose_n_oe <= !pph_pkg::RST_CTL_LINES[pph_pkg::CTL_CHOOSE_N];
        end
        else
        begin
            strobe_out <= 1'b0;
            auto_line_feed_n_out <= 1'b0;
            init_out <= 1'b0;
            printer_choose_n_out <= 1'b0;
            strobe_oe <= !ctl_lines[pph_pkg::CTL_STROBE_N];
            auto_line_feed_n_oe <= !ctl_lines[pph_pkg::CTL_AUTO_LF_N];
            init_oe <= !ctl_lines[pph_pkg::CTL_INIT];
            printer_choose_n_oe <= !ctl_lines[pph_pkg::CTL_CHOOSE_N];
        end
    end

    // acknowledge edge detect works on the synchronised level only
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            ack_prev <= 1'b1;
        else
            ack_prev <= ack_s;
    end

    assign ack_fall = ack_prev && !ack_s;

    // latched request; a new acknowledge beats a clearing status read
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            irq_pend <= 1'b0;
        else if (!strap_s)
            irq_pend <= 1'b0;
        else if (ack_fall)
            irq_pend <= 1'b1;
        else if (done && mapped && !pwrite && hit_status)
            irq_pend <= 1'b0;
    end

    // interrupt pin: tracks acknowledge, or shows the latch
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            printer_irq_n <= 1'b1;
        else if (!strap_s)
            printer_irq_n <= ack_s;
        else
            printer_irq_n <= !irq_pend;
    end

    // bus and printer line checks
    AST_IRQ_FOLLOW: assert property (@(posedge clock) disable iff (!rst_n)
        !strap_s && $stable(strap_s) |=> printer_irq_n == $past(ack_s))
        else $error("interrupt does not follow acknowledge");
    AST_IRQ_LATCH: assert property (@(posedge clock) disable iff (!rst_n)
        strap_s && ack_fall ##1 strap_s |=> !printer_irq_n)
        else $error("acknowledge edge not latched");
    AST_IRQ_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
        strap_s && done && mapped && !pwrite && hit_status && !ack_fall
        ##1 strap_s && !ack_fall |=> printer_irq_n)
        else $error("status read did not clear interrupt");
    AST_DATA_LATCH: assert property (@(posedge clock) disable iff (!rst_n)
        done && mapped && pwrite && hit_data |=> printer_data_out == $past(pwdata[7:0]))
        else $error("data byte not latched");
    AST_DATA_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
        !(done && pwrite) |=> $stable(printer_data_out) && $stable(printer_data_oe))
        else $error("data lines changed without a write");
    AST_SELECT_GATE: assert property (@(posedge clock) disable iff (!rst_n)
        access && !pready && !sel_s |=> pslverr && pready)
        else $error("access accepted while port deselected");
    AST_STROBE_DRIVE: assert property (@(posedge clock) disable iff (!rst_n)
        done && mapped && pwrite && hit_control && !pwdata[0] |=> ##1 strobe_oe && !strobe_out)
        else $error("strobe not driven low");
    AST_CHOOSE_DRIVE: assert property (@(posedge clock) disable iff (!rst_n)
        done && mapped && pwrite && hit_control |=> ##1 printer_choose_n_oe == !$past(pwdata[3], 2))
        else $error("select-in level wrong");
    AST_PREADY_PULSE: assert property (@(posedge clock) disable iff (!rst_n)
        pready |=> !pready)
        else $error("pready held longer than one cycle");
    AST_INIT_DRIVE: assert property (@(posedge clock) disable iff (!rst_n)
        done && mapped && pwrite && hit_control |=> ##1 init_oe == !$past(pwdata[2], 2))
        else $error("init line level wrong");
    AST_AUTO_DRIVE: assert property (@(posedge clock) disable iff (!rst_n)
        done && mapped && pwrite && hit_control |=> ##1 auto_line_feed_n_oe == !$past(pwdata[1], 2))
        else $error("auto line feed level wrong");
    AST_DIR_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
        done && mapped && pwrite && hit_control |=> printer_data_oe == $past(pwdata[4]))
        else $error("data direction not written");
    AST_ERR_WITH_READY: assert property (@(posedge clock) disable iff (!rst_n)
        pslverr |-> pready)
        else $error("error response without pready");
    AST_RDATA_IDLE: assert property (@(posedge clock) disable iff (!rst_n)
        !pready |-> prdata == 32'h0000_0000)
        else $error("read data outside the answer cycle");

    // scenarios worth seeing
    COV_WRITE_DATA: cover property (@(posedge clock) disable iff (!rst_n)
        done && mapped && pwrite && hit_data);
    COV_LATCH_CLEAR: cover property (@(posedge clock) disable iff (!rst_n)
        strap_s && irq_pend && done && !pwrite && hit_status);
    COV_FOLLOW_LOW: cover property (@(posedge clock) disable iff (!rst_n)
        !strap_s && !printer_irq_n);
    COV_REFUSED: cover property (@(posedge clock) disable iff (!rst_n) pslverr);
    COV_STROBE_LOW: cover property (@(posedge clock) disable iff (!rst_n)
        strobe_oe && sel_s);
endmodule

// >>> pph_printer_model.sv
`timescale 1ns/100ps
module pph_printer_model (
    // clock
    input wire logic clock,
    // control pins from the port
    input wire logic strobe_n_pin,
    input wire logic auto_lf_n_pin,
    input wire logic init_pin,
    input wire logic choose_n_pin,
    input wire logic [7:0] data_pin,
    // fault injection from the bench
    input wire logic make_fault,
    input wire logic make_paper_out,
    // status pins back to the port
    output logic fault_n,
    output logic printer_online,
    output logic busy,
    output logic paper_out,
    output logic ack_n,
    output logic [7:0] last_byte
);
    logic strobe_d = 1'h1;
    logic feed_on = 1'h0;
    logic [3:0] cnt = 4'h0;
    // fault levels held for as long as the condition lasts
    assign fault_n = !make_fault;
    assign paper_out = make_paper_out;
    assign printer_online = !choose_n_pin;
    assign busy = (cnt != 4'h0);
    // ack held low six cycles, long enough to cross the synchronisers
    assign ack_n = !(cnt != 4'h0 && cnt < 4'h7);
    // byte taken on the strobe fall only when idle, like a real printer
    always @(posedge clock)
    begin
        strobe_d <= strobe_n_pin;
        if (init_pin)
            cnt <= 4'h0;
        else if (strobe_d && !strobe_n_pin && cnt == 4'h0)
        begin
            last_byte <= data_pin;
            feed_on <= !auto_lf_n_pin;
            cnt <= 4'hC;
        end
        else if (cnt != 4'h0)
            cnt <= cnt - 4'h1;
    end
endmodule

// >>> printer_port_handshake_tb_top.sv
`timescale 1ns/100ps
module printer_port_handshake_tb_top;
    localparam logic [7:0] A_DAT = pph_pkg::OFS_DATA;
    localparam logic [7:0] A_STS = pph_pkg::OFS_STATUS;
    localparam logic [7:0] A_CTL = pph_pkg::OFS_CONTROL;
    logic clock, rst_n, psel, penable, pwrite, pready, pslverr, sel_n, strap, irq_n, err;
    logic [7:0] paddr, data_out, tb_data, data_pin, last_byte, r;
    logic [31:0] pwdata, prdata, rd;
    logic data_oe, stb_o, stb_oe, alf_o, alf_oe, ini_o, ini_oe, chs_o, chs_oe;
    logic stb_p, alf_p, ini_p, chs_p, fault_n, online, busy, paper, ack_n, mk_fault, mk_paper;
    int err_count = 0;
    int samples_checked = 0;
    // open-drain pins rest high on their pull-ups
    assign stb_p = stb_oe ? stb_o : 1'h1;
    assign alf_p = alf_oe ? alf_o : 1'h1;
    assign ini_p = ini_oe ? ini_o : 1'h1;
    assign chs_p = chs_oe ? chs_o : 1'h1;
    assign data_pin = data_oe ? data_out : tb_data;
    pph_port DUT (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .printer_port_select_n(sel_n), .printer_data_in(data_pin),
        .printer_data_out(data_out), .printer_data_oe(data_oe), .strobe_in(stb_p),
        .strobe_out(stb_o), .strobe_oe(stb_oe), .auto_line_feed_n_in(alf_p),
        .auto_line_feed_n_out(alf_o), .auto_line_feed_n_oe(alf_oe), .init_in(ini_p),
        .init_out(ini_o), .init_oe(ini_oe), .printer_choose_n_in(chs_p),
        .printer_choose_n_out(chs_o), .printer_choose_n_oe(chs_oe), .fault_n(fault_n),
        .printer_online(online), .busy(busy), .paper_out(paper), .ack_n(ack_n),
        .irq_latch_strap(strap), .printer_irq_n(irq_n));
    pph_printer_model prn (.clock(clock), .strobe_n_pin(stb_p), .auto_lf_n_pin(alf_p),
        .init_pin(ini_p), .choose_n_pin(chs_p), .data_pin(data_pin), .make_fault(mk_fault),
        .make_paper_out(mk_paper), .fault_n(fault_n), .printer_online(online), .busy(busy),
        .paper_out(paper), .ack_n(ack_n), .last_byte(last_byte));
    // control readback: line bits, mode bit, then pin levels
    function automatic logic [31:0] ctl_exp(input logic [3:0] ln, input logic dir);
        return {20'h0, ln, 3'h0, dir, ln};
    endfunction
    // idle status, pending bit left out of the compare
    function automatic logic [31:0] sts_exp(input logic st, on, flt, pp);
        return {25'h0, st, 1'h0, 1'h1, pp, 1'h0, on, !flt};
    endfunction
    task automatic wrap_up();
        $display("mismatches %0d, checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; an idle edge after it keeps drives one per step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'h1;
        @(posedge clock);
        while (pready !== 1'h1 && n < 20)
        begin
            @(posedge clock);
            n++;
        end
        if (pready !== 1'h1)
        begin
            err_count++;
            $display("apb transfer timed out at %0t", $time);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clock);
    endtask
    task automatic chk_sts(input logic [31:0] exp);
        apb(1'h0, A_STS, 32'h0);
        check(rd & 32'hFFFFFFDF, exp);
    endtask
    // latch a byte, strobe it by software, follow the printer's reply
    task automatic print_byte(input logic [7:0] b, input logic [3:0] ln);
        int n;
        n = 0;
        apb(1'h1, A_DAT, {24'h0, b});
        check(32'(data_out), 32'(b));
        check(32'(data_oe), 32'h1);
        apb(1'h1, A_CTL, {28'h1, ln & 4'hE});
        apb(1'h1, A_CTL, {28'h1, ln});
        while (ack_n !== 1'h0 && n < 40)
        begin
            @(posedge clock);
            n++;
        end
        if (ack_n !== 1'h0)
        begin
            err_count++;
            $display("acknowledge wait timed out at %0t", $time);
        end
        repeat (4) @(posedge clock);
        check(32'(irq_n), 32'h0);
        while (busy !== 1'h0 && n < 80)
        begin
            @(posedge clock);
            n++;
        end
        if (busy !== 1'h0)
        begin
            err_count++;
            $display("busy wait timed out at %0t", $time);
        end
        check(32'(last_byte), 32'(b));
    endtask
    // free-running bench clock
    initial
    begin
        clock = 1'h0;
        forever #4 clock = ~clock;
    end
    // watchdog, far beyond the few hundred cycles the tests need
    initial
    begin
        #200000;
        err_count++;
        wrap_up();
    end
    // main sequence
    initial
    begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {sel_n, strap, tb_data, mk_fault, mk_paper} = '0;
        void'($urandom(32'h3986));
        repeat (2) @(posedge clock);
        rst_n <= 1'h1;
        apb(1'h0, A_CTL, 32'h0);
        check(rd, ctl_exp(4'hB, 1'h1));
        chk_sts(sts_exp(1'h0, 1'h0, 1'h0, 1'h0));
        for (int i = 0; i < 4; i++)
        begin
            apb(1'h1, A_CTL, {28'h1, 2'h0, i[0], 1'h1});
            repeat (3) @(posedge clock);
            apb(1'h0, A_CTL, 32'h0);
            check(rd, ctl_exp({2'h0, i[0], 1'h1}, 1'h1));
            print_byte(8'($urandom()), {2'h0, i[0], 1'h1});
            chk_sts(sts_exp(1'h0, 1'h1, 1'h0, 1'h0));
        end
        for (int i = 0; i < 4; i++)
        begin
            {mk_fault, mk_paper} <= 2'(i);
            repeat (3) @(posedge clock);
            chk_sts(sts_exp(1'h0, 1'h1, i[1], i[0]));
        end
        {mk_fault, mk_paper} <= 2'h0;
        strap <= 1'h1;
        repeat (3) @(posedge clock);
        r = 8'($urandom());
        print_byte(r, 4'h3);
        repeat (4) @(posedge clock);
        check(32'(irq_n), 32'h0);
        chk_sts(sts_exp(1'h1, 1'h1, 1'h0, 1'h0));
        check({31'h0, rd[5]}, 32'h1);
        repeat (2) @(posedge clock);
        check(32'(irq_n), 32'h1);
        sel_n <= 1'h1;
        repeat (3) @(posedge clock);
        apb(1'h1, A_DAT, {24'h0, ~r});
        check(32'({err, data_out}), 32'({1'h1, r}));
        apb(1'h0, A_STS, 32'h0);
        check(32'(err), 32'h1);
        check(rd, 32'h0);
        sel_n <= 1'h0;
        repeat (3) @(posedge clock);
        apb(1'h0, 8'h0C, 32'h0);
        check(32'(err), 32'h1);
        check(rd, 32'h0);
        apb(1'h1, A_CTL, 32'h3);
        check(32'(data_oe), 32'h0);
        tb_data <= 8'($urandom());
        repeat (3) @(posedge clock);
        apb(1'h0, A_DAT, 32'h0);
        check(rd, {24'h0, tb_data});
        wrap_up();
    end
endmodule
